// ==== psg_top.sv ====
// Purpose: six channel pwm generator with register port
// Assumes: pll_tick and xtal_tick are single cycle pulses in the clk domain
// Notes:   reads return data in the cycle after the read strobe only
//
// Functional notes
// R1 - Up to six channels run side by side, each with its own settings and pin.
// R2 - Each channel drives a two-level wave whose duty is set by software.
// R3 - Each channel times its phases by counting ticks of its chosen source.
// R4 - High and low phases each have their own 16-bit divider value.
// R5 - A channel either updates alone or joins a group update with others.
// R6 - A channel pair can be set so the odd pin is the inverse of the even pin; here the odd pin is held low while the even channel is off.
// R7 - Each channel repeats its wave or gives one pulse and then stops.
// R8 - The source is either the fast pll tick or the crystal-rate tick.
// R9 - A group update starts all members together at a period boundary.
// R10 - After reset every channel is off and its pin is low.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module psg_top
  import psg_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DOC,
  parameter int DIV_W  = DIV_W_DOC
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  input  wire logic              pll_tick,
  input  wire logic              xtal_tick,
  output var  logic [NUM_CH-1:0] pwm_out
);

  localparam int NPAIR = NUM_CH / 2;

  // refuse sizes the register map cannot hold
  if (NUM_CH < 2 || NUM_CH > NUM_CH_DOC)
    $error("psg_top: NUM_CH must be 2 to 6");
  if (DIV_W < 1 || DIV_W > DIV_W_DOC)
    $error("psg_top: DIV_W must be 1 to 16");

  //////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic ch_hit(input logic [7:0] a, input int i,
                                  input logic [7:0] ofs);
    logic [7:0] base;
    base   = 8'(i) * CH_STRIDE;
    ch_hit = (a == base + ofs);
  endfunction

  function automatic logic [DATA_W-1:0] zext(input logic [DIV_W-1:0] v);
    zext = {{(DATA_W-DIV_W){1'b0}}, v};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register file state
  logic [CTRL_W-1:0] ctrl_reg  [NUM_CH];
  logic [CTRL_W-1:0] ctrl_next [NUM_CH];
  logic [DIV_W-1:0]  hi_reg    [NUM_CH];
  logic [DIV_W-1:0]  hi_next   [NUM_CH];
  logic [DIV_W-1:0]  lo_reg    [NUM_CH];
  logic [DIV_W-1:0]  lo_next   [NUM_CH];
  logic [NPAIR-1:0]  inv_reg,   inv_next;
  logic [NUM_CH-1:0] arm_pulse_reg, arm_pulse_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [NUM_CH-1:0] pin_reg,   pin_next;

  // channel feedback
  logic [NUM_CH-1:0] ch_out;
  logic [NUM_CH-1:0] ch_ready;
  logic [NUM_CH-1:0] ch_armed;
  logic [NUM_CH-1:0] ch_done;
  logic              release_all;

  //////////////////////////////////////////////////////////////////////////
  // channel instances
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    psg_ch_if #(.DIV_W(DIV_W)) chb ();

    assign chb.en          = ctrl_reg[g][CTRL_EN];
    assign chb.cont        = ctrl_reg[g][CTRL_CONT];
    assign chb.sel_pll     = ctrl_reg[g][CTRL_PLL]; // R8
    assign chb.sync        = ctrl_reg[g][CTRL_SYNC];
    assign chb.shd_hi      = hi_reg[g];
    assign chb.shd_lo      = lo_reg[g];
    assign chb.tick_pll    = pll_tick;
    assign chb.tick_xtal   = xtal_tick;
    assign chb.arm         = arm_pulse_reg[g];
    assign chb.release_all = release_all;
    assign ch_out[g]       = chb.out;
    assign ch_ready[g]     = chb.ready;
    assign ch_armed[g]     = chb.armed;
    assign ch_done[g]      = chb.done;

    psg_channel #(.DIV_W(DIV_W)) u_ch
    (
      .clk (clk),
      .rst (rst),
      .bus (chb)
    ); // R1
  end

  // group release once every armed channel sits at its period boundary
  assign release_all = (|ch_armed) && (&(ch_ready | ~ch_armed)); // R9

  //////////////////////////////////////////////////////////////////////////
  // register writes, read mux and pin mapping
  always_comb
  begin
    inv_next       = inv_reg;
    arm_pulse_next = '0;
    rdata_next     = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      ctrl_next[i] = ctrl_reg[i];
      hi_next[i]   = hi_reg[i];
      lo_next[i]   = lo_reg[i];
      if (reg_wr && ch_hit(reg_addr, i, OFS_CTRL))
        ctrl_next[i] = reg_wdata[CTRL_W-1:0];
      if (reg_wr && ch_hit(reg_addr, i, OFS_HIGH))
        hi_next[i] = reg_wdata[DIV_W-1:0]; // R4
      if (reg_wr && ch_hit(reg_addr, i, OFS_LOW))
        lo_next[i] = reg_wdata[DIV_W-1:0]; // R4
      if (reg_rd && ch_hit(reg_addr, i, OFS_CTRL))
        rdata_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg[i]};
      if (reg_rd && ch_hit(reg_addr, i, OFS_HIGH))
        rdata_next = zext(hi_reg[i]);
      if (reg_rd && ch_hit(reg_addr, i, OFS_LOW))
        rdata_next = zext(lo_reg[i]);
    end
    // group update only arms channels set for sync mode
    if (reg_wr && reg_addr == ADDR_UPDATE)
      for (int i = 0; i < NUM_CH; i++)
        arm_pulse_next[i] = reg_wdata[i] && ctrl_reg[i][CTRL_SYNC]; // R5
    if (reg_wr && reg_addr == ADDR_PAIRINV)
      inv_next = reg_wdata[NPAIR-1:0]; // R6
    if (reg_rd && reg_addr == ADDR_PAIRINV)
      rdata_next = {{(DATA_W-NPAIR){1'b0}}, inv_reg};
    if (reg_rd && reg_addr == ADDR_STATUS)
    begin
      rdata_next[STAT_OUT +: NUM_CH]  = pin_reg;
      rdata_next[STAT_DONE +: NUM_CH] = ch_done;
      rdata_next[STAT_ARM +: NUM_CH]  = ch_armed;
    end
    // odd pin follows the inverted even pin while its pair is inverted and the even channel is enabled, low while that channel is off, else its own channel
    pin_next = ch_out;
    for (int k = 0; k < NPAIR; k++)
      if (inv_reg[k])
        pin_next[2*k+1] = ctrl_reg[2*k][CTRL_EN] && !ch_out[2*k]; // R6
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        ctrl_reg[i] <= CTRL_RST; // R10
        hi_reg[i]   <= DIV_RST[DIV_W-1:0];
        lo_reg[i]   <= DIV_RST[DIV_W-1:0];
      end
      inv_reg       <= '0;
      arm_pulse_reg <= '0;
      rdata_reg     <= '0;
      pin_reg       <= '0; // R10
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        ctrl_reg[i] <= ctrl_next[i];
        hi_reg[i]   <= hi_next[i];
        lo_reg[i]   <= lo_next[i];
      end
      inv_reg       <= inv_next;
      arm_pulse_reg <= arm_pulse_next;
      rdata_reg     <= rdata_next;
      pin_reg       <= pin_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pwm_out   = pin_reg;

endmodule // psg_top
`default_nettype wire

// ==== psg_pkg.sv ====
// Purpose: shared constants and types for the six channel pwm generator
// Assumes: byte addressed register port with 8-bit address, 32-bit data
// Notes:   per-channel registers repeat every CH_STRIDE bytes
package psg_pkg;

  localparam int          NUM_CH_DOC   = 6;
  localparam int          DIV_W_DOC    = 16;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;

  // per-channel register block
  localparam logic [7:0]  CH_STRIDE    = 8'h10;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_HIGH     = 8'h04;
  localparam logic [7:0]  OFS_LOW      = 8'h08;

  // global registers
  localparam logic [7:0]  ADDR_UPDATE  = 8'h60;
  localparam logic [7:0]  ADDR_PAIRINV = 8'h64;
  localparam logic [7:0]  ADDR_STATUS  = 8'h68;

  // control field positions
  localparam int          CTRL_EN      = 0;
  localparam int          CTRL_CONT    = 1;
  localparam int          CTRL_PLL     = 2;
  localparam int          CTRL_SYNC    = 3;
  localparam int          CTRL_W       = 4;

  // status field positions
  localparam int          STAT_OUT     = 0;
  localparam int          STAT_DONE    = 8;
  localparam int          STAT_ARM     = 16;

  // reset values
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [15:0] DIV_RST      = 16'h0000;

  // channel states, gray along idle-high-low-wait-stop
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_HIGH = 3'b001,
    ST_LOW  = 3'b011,
    ST_WAIT = 3'b010,
    ST_STOP = 3'b110
  } psg_state_t;

endpackage

// ==== psg_ch_if.sv ====
// Purpose: bundle between the register file and one pwm channel
// Assumes: all signals synchronous to clk
// Notes:   arm and release are single cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface psg_ch_if #(parameter int DIV_W = 16);
  logic             en;
  logic             cont;
  logic             sel_pll;
  logic             sync;
  logic [DIV_W-1:0] shd_hi;
  logic [DIV_W-1:0] shd_lo;
  logic             tick_pll;
  logic             tick_xtal;
  logic             arm;
  logic             release_all;
  logic             out;
  logic             ready;
  logic             armed;
  logic             done;

  modport ctl (output en, cont, sel_pll, sync, shd_hi, shd_lo, tick_pll,
               tick_xtal, arm, release_all,
               input out, ready, armed, done);
  modport ch  (input en, cont, sel_pll, sync, shd_hi, shd_lo, tick_pll,
               tick_xtal, arm, release_all,
               output out, ready, armed, done);
endinterface
`default_nettype wire

// ==== psg_channel.sv ====
// Purpose: one pwm channel, high and low phases timed by separate dividers
// Assumes: tick inputs are one-cycle pulses of the two source clocks
// Notes:   a divider value d gives a phase of d+1 source ticks
`timescale 1ns/1ps
`default_nettype none
module psg_channel
  import psg_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input wire logic clk,
  input wire logic rst,
  psg_ch_if.ch     bus
);

  psg_state_t       state_reg, state_next;
  logic [DIV_W-1:0] cnt_reg,   cnt_next;
  logic [DIV_W-1:0] hi_reg,    hi_next;
  logic [DIV_W-1:0] lo_reg,    lo_next;
  logic             arm_reg,   arm_next;
  logic             out_reg,   out_next;
  logic             tick;

  //////////////////////////////////////////////////////////////////////////
  // next state: count ticks of the chosen source through each phase
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    hi_next    = hi_reg;
    lo_next    = lo_reg;
    arm_next   = arm_reg;
    tick       = bus.sel_pll ? bus.tick_pll : bus.tick_xtal; // R8
    case (state_reg)
      ST_IDLE:
      begin
        arm_next = 1'b0;
        if (bus.en)
        begin
          hi_next    = bus.shd_hi;
          lo_next    = bus.shd_lo;
          cnt_next   = '0;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH:
        if (tick)
        begin
          if (cnt_reg == hi_reg) // R4
          begin
            cnt_next   = '0;
            state_next = ST_LOW;
          end
          else
            cnt_next = cnt_reg + 1'b1; // R3
        end
      ST_LOW:
        if (tick)
        begin
          if (cnt_reg == lo_reg) // R4
          begin
            cnt_next = '0;
            // period boundary: hold for a group update, stop, or go on
            if (arm_reg)
              state_next = ST_WAIT; // R9
            else if (!bus.cont)
              state_next = ST_STOP; // R7
            else
            begin
              if (!bus.sync)
              begin
                hi_next = bus.shd_hi; // R5
                lo_next = bus.shd_lo;
              end
              state_next = ST_HIGH; // R7
            end
          end
          else
            cnt_next = cnt_reg + 1'b1; // R3
        end
      ST_WAIT, ST_STOP:
        if (bus.release_all && arm_reg)
        begin
          hi_next    = bus.shd_hi; // R9
          lo_next    = bus.shd_lo;
          arm_next   = 1'b0;
          cnt_next   = '0;
          state_next = ST_HIGH;
        end
      default:
        state_next = ST_IDLE;
    endcase
    // a new arm beats the release of the same cycle
    if (bus.arm && bus.en)
      arm_next = 1'b1; // R5
    if (!bus.en)
    begin
      state_next = ST_IDLE; // R10
      cnt_next   = '0;
      arm_next   = 1'b0;
    end
    out_next = (state_next == ST_HIGH); // R2
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE; // R10
      cnt_reg   <= '0;
      hi_reg    <= DIV_RST[DIV_W-1:0];
      lo_reg    <= DIV_RST[DIV_W-1:0];
      arm_reg   <= 1'b0;
      out_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      hi_reg    <= hi_next;
      lo_reg    <= lo_next;
      arm_reg   <= arm_next;
      out_reg   <= out_next;
    end
  end

  assign bus.out   = out_reg;
  assign bus.armed = arm_reg;
  assign bus.ready = arm_reg && (state_reg == ST_WAIT || state_reg == ST_STOP);
  assign bus.done  = (state_reg == ST_STOP);

endmodule // psg_channel
`default_nettype wire

// ==== psg_top_asserts.sv ====
// Purpose: port level checks for the pwm generator
// Assumes: shadows of ch0 enable and pair0 invert follow the writes
// Notes:   status mirror assumes pins are sampled at the read edge
`timescale 1ns/1ps
`default_nettype none
module psg_top_asserts
  import psg_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DOC,
  parameter int DIV_W  = DIV_W_DOC
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              pll_tick,
  input wire logic              xtal_tick,
  input wire logic [NUM_CH-1:0] pwm_out
);
  logic en0;
  logic pinv0;
  ////////////////////////////////////////////////////////////
  // shadows rebuilt from strobes, so no peeking into the body
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      en0   <= 1'b0;
      pinv0 <= 1'b0;
    end
    else if (reg_wr && reg_addr == OFS_CTRL)
      en0 <= reg_wdata[CTRL_EN];
    else if (reg_wr && reg_addr == ADDR_PAIRINV)
      pinv0 <= reg_wdata[0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (reg_rd && reg_addr >= 8'h6C
    |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  reset_low_a: assert property ($fell(rst)
    |-> pwm_out == '0 && reg_rdata == '0)
    else $error("outputs not low after reset");
  status_pins_a: assert property (reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[NUM_CH-1:0] == $past(pwm_out))
    else $error("status does not mirror pins");
  enable_rise_a: assert property (reg_wr && reg_addr == OFS_CTRL
    && reg_wdata[CTRL_EN] && !reg_wdata[CTRL_SYNC] && !en0
    |-> ##[2:3] pwm_out[0])
    else $error("channel 0 did not start high");
  disable_fall_a: assert property (reg_wr && reg_addr == OFS_CTRL
    && !reg_wdata[CTRL_EN] |-> ##[1:4] !pwm_out[0])
    else $error("channel 0 not low after disable");
  off_low_a: assert property ((!en0)[*4] |-> !pwm_out[0])
    else $error("disabled channel 0 drives high");
  pair_inv_a: assert property (pinv0 && $past(pinv0, 3) && en0
    && $past(en0, 3) |-> pwm_out[1] != pwm_out[0])
    else $error("pair 0 not inverted");
endmodule // psg_top_asserts
bind psg_top psg_top_asserts #(.NUM_CH(NUM_CH), .DIV_W(DIV_W)) chk_u
  (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pll_tick(pll_tick), .xtal_tick(xtal_tick), .pwm_out(pwm_out));
`default_nettype wire

// ==== psg_load.sv ====
// Purpose: load on the pwm pins, measures run lengths of one pin
// Assumes: pins settle once per clk cycle
// Notes:   a change of sel may record one partial run
`timescale 1ns/1ps
`default_nettype none
module psg_load
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  pins,
  input  wire logic [2:0]  sel,
  output var  logic [15:0] hi_len,
  output var  logic [15:0] lo_len
);
  logic [15:0] run;
  logic        last;
  ////////////////////////////////////////////////////////////
  // a load sees only edges, so lengths are whole clk cycles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run    <= '0;
      last   <= 1'b0;
      hi_len <= '0;
      lo_len <= '0;
    end
    else if (pins[sel] != last)
    begin
      if (last)
        hi_len <= run;
      else
        lo_len <= run;
      run  <= 16'h1;
      last <= pins[sel];
    end
    else
      run <= run + 16'h1;
  end
endmodule // psg_load
`default_nettype wire

// ==== test_pwm_six_channel_generator.sv ====
// Purpose: self-checking bench for the pwm generator
// Assumes: pll tick every 2 cycles, crystal tick every 5
// Notes:   phase lengths come from the load model, in clk cycles
`timescale 1ns/1ps
`default_nettype none
module test_pwm_six_channel_generator
  import psg_pkg::*;
;
  logic        clk, rst, reg_wr, reg_rd, pll_tick, xtal_tick;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [5:0]  pwm_out;
  logic [2:0]  sel;
  logic [15:0] hi_len, lo_len;
  logic [3:0]  tc;
  int          err_total, compares, n;
  psg_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pll_tick(pll_tick), .xtal_tick(xtal_tick),
    .pwm_out(pwm_out));
  psg_load load_u (.clk(clk), .rst(rst), .pins(pwm_out), .sel(sel),
    .hi_len(hi_len), .lo_len(lo_len));
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // source ticks; the unselected one must be ignored
  always @(posedge clk)
  begin
    tc        <= (tc == 4'h9) ? 4'h0 : tc + 4'h1;
    pll_tick  <= tc[0];
    xtal_tick <= (tc == 4'h4) || (tc == 4'h9);
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= {16'h0000, v};
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // pin b must follow pin a, inverted when inv is set
  task automatic same(input int a, b, input logic inv);
    repeat (20)
    begin
      @(negedge clk);
      chk("pin pair", 32'(pwm_out[a] ^ inv), 32'(pwm_out[b]));
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    // each bus signal set on its own, so no field slips by a bit
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    {tc, pll_tick, xtal_tick, sel} = 9'h000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pins after reset", 32'h0, 32'(pwm_out));
    rd(OFS_CTRL);
    chk("ctrl0 reset", 32'h0, d);
    rd(8'h70);
    chk("unmapped read", 32'h0, d);
    wr(OFS_HIGH, 16'h0002);
    wr(OFS_LOW, 16'h0003);
    rd(OFS_HIGH);
    chk("ch0 high divider", 32'h2, d);
    wr(OFS_CTRL, 16'h0007);
    wr(8'h14, 16'h0001);
    wr(8'h18, 16'h0000);
    wr(8'h10, 16'h0003);
    repeat (120) @(posedge clk);
    chk("ch0 high", 32'h6, 32'(hi_len));
    chk("ch0 low", 32'h8, 32'(lo_len));
    sel <= 3'h1;
    repeat (60) @(posedge clk);
    chk("ch1 high", 32'hA, 32'(hi_len));
    chk("ch1 low", 32'h5, 32'(lo_len));
    wr(ADDR_PAIRINV, 16'h0001);
    rd(ADDR_PAIRINV);
    chk("pair invert reg", 32'h1, d);
    repeat (4) @(posedge clk);
    same(0, 1, 1'b1);
    wr(ADDR_PAIRINV, 16'h0000);
    sel <= 3'h2;
    wr(8'h24, 16'h0000);
    wr(8'h28, 16'h0001);
    wr(8'h20, 16'h0005);
    repeat (40) @(posedge clk);
    chk("ch2 pulse", 32'h1, 32'(hi_len >= 1 && hi_len <= 2));
    rd(ADDR_STATUS);
    chk("ch2 done", 32'h1, 32'(d[STAT_DONE+2]));
    chk("ch2 pin", 32'h0, 32'(d[2]));
    wr(8'h44, 16'h0001);
    wr(8'h48, 16'h0001);
    wr(8'h54, 16'h0001);
    wr(8'h58, 16'h0001);
    wr(8'h40, 16'h000F);
    wr(8'h50, 16'h000F);
    // ch4 and ch5 run free one tick apart, so both can be high
    // by chance; only after the group release are they in step
    wr(ADDR_UPDATE, 16'h0030);
    rd(ADDR_STATUS);
    chk("group armed", 32'h3, 32'(d[STAT_ARM+4 +: 2]));
    repeat (16) @(posedge clk);
    rd(ADDR_STATUS);
    chk("group released", 32'h0, 32'(d[STAT_ARM+4 +: 2]));
    n = 0;
    while (pwm_out[5:4] !== 2'b11 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk("group start", 32'h1, 32'(n < 60));
    if (n >= 60)
      conclude();
    same(4, 5, 1'b0);
    wr(OFS_CTRL, 16'h0000);
    repeat (5) @(posedge clk);
    chk("ch0 off", 32'h0, 32'(pwm_out[0]));
    conclude();
  end
endmodule // test_pwm_six_channel_generator
`default_nettype wire
